// File: hdl/pvc_vendor_control.sv
// Overview of operation
// R1 - Writing one to the soft reset bit restores registers to defaults; bit self-clears. Here only fast control is restored; ten control keeps its value.
// R2 - Transmitter-off bit at zero holds line outputs idle; resets to one.
// R3 - Carrier sense from receive only when select is one, else receive or transmit.
// R4 - Link error enable puts the link error code on RXD during RX_ER.
// R5 - Packet error enable puts the unlocked code on RXD during RX_ER. Here only while scrambler_unlocked; link error enable wins.
// R6 - Coder bypass one disables 4B/5B encoder and decoder; default zero.
// R7 - Coding sublayer strap low presets coder and scrambler bypass to one.
// R8 - Symbol aligner bypass one disables receive alignment; default zero.
// R9 - Scrambler bypass one disables scrambling and descrambling; default zero.
// R10 - Carrier integrity enable turns on integrity monitoring; default zero.
// R11 - Jam-to-collision bit ORs the carrier integrity jam into COL.
// R12 - Software writes zero to reserved fast control bits.
// R13 - Heartbeat enable runs signal quality error at 10 Mbit/s only.
// R14 - Extended line length lowers squelch threshold at 10 Mbit/s.
// R15 - Polarity correct enable detects, flags and corrects reversal at 10 Mbit/s.
// R16 - Reference select chooses external reference clock for phase alignment.
// R17 - Serial select picks 10 Mbit/s serial mode, ignored at 100 Mbit/s.
// R18 - No-link-partner bit runs 10 Mbit/s without link pulses.
// R19 - Mode straps sampled at reset preset writable default bits.
// R20 - Unconnected straps give code 111, all capable with autonegotiation.
// R21 - Codes 000 to 011 force fixed mode; bit0 duplex, bit1 speed.
// R22 - Code 100 autonegotiates advertising only 100Base-TX half duplex.
// R23 - Code 110 sets isolate and speed, advertises 10 modes only; 101 reserved.
// R24 - Polarity flag reads one after detected reversal; default zero.
// R25 - Preset bits follow control layout: 13 speed, 12 autoneg, 10 isolate, 8 duplex.
`timescale 1ns/10ps
`default_nettype none
module pvc_vendor_control
#(
  parameter logic [3:0] UNLOCKED_CODE = 4'h2
)
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [2:0]  mode_strap,
  input  wire logic        coding_sublayer_enable_strap,
  input  wire logic [4:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  output logic             reg_rvalid,
  output logic             soft_register_reset,
  output logic      [15:0] strap_control_preset,
  output logic      [15:0] strap_advert_preset,
  output logic             factory_test_reset_a,
  output logic             factory_test_reset_b,
  output logic             coder_bypass,
  output logic             symbol_aligner_bypass,
  output logic             scrambler_bypass,
  output logic             carrier_integrity_enable,
  output logic             heartbeat_active,
  output logic             squelch_reduced,
  output logic             polarity_correct_active,
  output logic             use_external_reference,
  output logic             serial_mode_active,
  output logic             no_link_partner_active,
  input  wire logic        speed_100,
  input  wire logic        tx_line_p_in,
  input  wire logic        tx_line_n_in,
  output logic             line_p,
  output logic             line_n,
  input  wire logic        rx_active,
  input  wire logic        tx_active,
  output logic             crs,
  input  wire logic        rx_er,
  input  wire logic [3:0]  rxd_in,
  input  wire logic [3:0]  link_error_code,
  input  wire logic        scrambler_unlocked,
  output logic      [3:0]  rxd,
  input  wire logic        col_in,
  input  wire logic        jam_in,
  output logic             col,
  input  wire logic        polarity_reversal_seen,
  output logic             polarity_reversed_flag
);

  typedef struct packed {
    logic        taken;
    logic        pcs_bypass;
    logic [15:0] fast;
    logic [5:0]  ten;
    logic [15:0] ctrl0;
    logic [15:0] adv;
    logic        pol_flag;
    logic [15:0] rdata;
    logic        rvalid;
    logic        soft_rst;
    logic        crs;
    logic        col;
    logic [3:0]  rxd;
    logic        line_p;
    logic        line_n;
  } pvc_state_t;

  pvc_state_t  q;
  pvc_state_t  next_q;
  logic [15:0] dec_ctrl;
  logic [15:0] dec_adv;
  logic [15:0] fast_default;
  logic        wr_fast;
  logic        wr_ten;

  ////////////////////////////////////////////////////////////////////////////////
  // Strap decode

  pvc_strap_decode pvc_strap_decode_inst
  (
    .mode_strap   (mode_strap),
    .control_bits (dec_ctrl),
    .advert_bits  (dec_adv)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    wr_fast      = reg_wr && (reg_addr == pvc_pkg::FAST_CTRL_ADDR) && q.taken;
    wr_ten       = reg_wr && (reg_addr == pvc_pkg::TEN_CTRL_ADDR) && q.taken;
    fast_default = pvc_pkg::FAST_RESET | (q.pcs_bypass ? pvc_pkg::FAST_PCS_BYP : 16'h0000);
    next_q          = q;
    next_q.soft_rst = 1'b0;
    next_q.rvalid   = 1'b0;
    if (!q.taken)
    begin
      // First edge after release latches the straps
      next_q.taken      = 1'b1;                                            // [R19]
      next_q.ctrl0      = dec_ctrl;                                        // [R20] [R21] [R22] [R23] [R25]
      next_q.adv        = dec_adv;                                         // [R20] [R21] [R22] [R23]
      next_q.pcs_bypass = !coding_sublayer_enable_strap;
      next_q.fast       = pvc_pkg::FAST_RESET |
                          (coding_sublayer_enable_strap ? 16'h0000 : pvc_pkg::FAST_PCS_BYP); // [R7]
    end
    else
    begin
      if (wr_fast)
      begin
        if (reg_wdata[pvc_pkg::FC_SOFT_RST])
        begin
          next_q.fast     = fast_default;                                  // [R1]
          next_q.soft_rst = 1'b1;                                          // [R1]
        end
        else
        begin
          next_q.fast = reg_wdata;                                         // [R12]
        end
      end
      if (wr_ten)
      begin
        next_q.ten = reg_wdata[pvc_pkg::TEN_W-1:0];
      end
      if (reg_rd)
      begin
        next_q.rvalid = 1'b1;
        unique case (reg_addr)
          pvc_pkg::FAST_CTRL_ADDR: next_q.rdata = q.fast;
          pvc_pkg::TEN_CTRL_ADDR:  next_q.rdata = {10'h000, q.ten};
          pvc_pkg::VEND_STAT_ADDR:
          begin
            next_q.rdata = 16'h0000;
            next_q.rdata[pvc_pkg::VS_POL_FLAG] = q.pol_flag;                // [R24]
          end
          default:                 next_q.rdata = 16'h0000;
        endcase
      end
    end
    // Polarity status is live, meaningless at 100 Mbit/s
    next_q.pol_flag = q.ten[pvc_pkg::TC_POL] && !speed_100 && polarity_reversal_seen
                      && !(wr_fast && reg_wdata[pvc_pkg::FC_SOFT_RST]);     // [R15] [R24]
    // Line idles at p low, n high while transmitter is off
    next_q.line_p = q.fast[pvc_pkg::FC_TX_ON] ? tx_line_p_in : 1'b0;        // [R2]
    next_q.line_n = q.fast[pvc_pkg::FC_TX_ON] ? tx_line_n_in : 1'b1;        // [R2]
    next_q.crs    = rx_active || (!q.fast[pvc_pkg::FC_CRS_RX_ONLY] && tx_active); // [R3]
    next_q.col    = col_in || (q.fast[pvc_pkg::FC_JAM_COL] && jam_in);     // [R11]
    next_q.rxd    = rxd_in;
    if (rx_er && q.fast[pvc_pkg::FC_LINK_ERR])
    begin
      next_q.rxd = link_error_code;                                        // [R4]
    end
    else if (rx_er && q.fast[pvc_pkg::FC_UNLOCK_ERR] && scrambler_unlocked)
    begin
      next_q.rxd = UNLOCKED_CODE;                                          // [R5]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q            <= '0;
      q.fast       <= pvc_pkg::FAST_RESET;
      q.ten        <= pvc_pkg::TEN_RESET;
      q.line_n     <= 1'b1;
    end
    else
    begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata                = q.rdata;
  assign reg_rvalid               = q.rvalid;
  assign soft_register_reset      = q.soft_rst;                            // [R1]
  assign strap_control_preset     = q.ctrl0;                               // [R19]
  assign strap_advert_preset      = q.adv;
  assign factory_test_reset_a     = q.fast[pvc_pkg::FC_TEST_A];
  assign factory_test_reset_b     = q.fast[pvc_pkg::FC_TEST_B];
  assign coder_bypass             = q.fast[pvc_pkg::FC_CODER_BYP];         // [R6]
  assign symbol_aligner_bypass    = q.fast[pvc_pkg::FC_ALIGN_BYP];         // [R8]
  assign scrambler_bypass         = q.fast[pvc_pkg::FC_SCRAM_BYP];         // [R9]
  assign carrier_integrity_enable = q.fast[pvc_pkg::FC_CARR_INT];          // [R10]
  assign heartbeat_active         = q.ten[pvc_pkg::TC_HBT] && !speed_100;  // [R13]
  assign squelch_reduced          = q.ten[pvc_pkg::TC_ELL] && !speed_100;  // [R14]
  assign polarity_correct_active  = q.ten[pvc_pkg::TC_POL] && !speed_100;  // [R15]
  assign use_external_reference   = q.ten[pvc_pkg::TC_REF];                // [R16]
  assign serial_mode_active       = q.ten[pvc_pkg::TC_SERIAL] && !speed_100; // [R17]
  assign no_link_partner_active   = q.ten[pvc_pkg::TC_NO_LP] && !speed_100;  // [R18]
  assign line_p                   = q.line_p;
  assign line_n                   = q.line_n;
  assign crs                      = q.crs;
  assign col                      = q.col;
  assign rxd                      = q.rxd;
  assign polarity_reversed_flag   = q.pol_flag;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_soft_reset_clears: assert property ( // [R1]
    wr_fast && reg_wdata[pvc_pkg::FC_SOFT_RST]
    |=> soft_register_reset && !q.fast[pvc_pkg::FC_SOFT_RST]
        && q.fast[pvc_pkg::FC_TX_ON] ##1 !soft_register_reset)
    else $error("soft reset did not restore defaults");

  chk_tx_off_idle: assert property ( // [R2]
    q.taken && !q.fast[pvc_pkg::FC_TX_ON] |=> !line_p && line_n)
    else $error("line not idle while transmitter off");

  chk_crs_either: assert property ( // [R3]
    !q.fast[pvc_pkg::FC_CRS_RX_ONLY] && tx_active && !rx_active |=> crs)
    else $error("carrier sense missed transmit activity");

  chk_crs_rx_only: assert property ( // [R3]
    q.fast[pvc_pkg::FC_CRS_RX_ONLY] && !rx_active |=> !crs)
    else $error("carrier sense raised without receive");

  chk_link_err_code: assert property ( // [R4]
    rx_er && q.fast[pvc_pkg::FC_LINK_ERR] |=> rxd == $past(link_error_code))
    else $error("link error code not reported");

  chk_unlock_code: assert property ( // [R5]
    rx_er && !q.fast[pvc_pkg::FC_LINK_ERR] && q.fast[pvc_pkg::FC_UNLOCK_ERR]
    && scrambler_unlocked |=> rxd == UNLOCKED_CODE)
    else $error("unlocked code not reported");

  chk_strap_bypass: assert property ( // [R7]
    !q.taken && !coding_sublayer_enable_strap |=> coder_bypass && scrambler_bypass)
    else $error("strap did not preset bypass bits");

  chk_jam_col: assert property ( // [R11]
    jam_in && q.fast[pvc_pkg::FC_JAM_COL] |=> col)
    else $error("jam not merged into collision");

  chk_serial_ignored: assert property ( // [R17]
    speed_100 |-> !serial_mode_active && !no_link_partner_active && !heartbeat_active)
    else $error("10 Mbit/s control active at 100 Mbit/s");

  chk_polarity_flag: assert property ( // [R15]
    q.taken && polarity_reversal_seen && polarity_correct_active && !wr_fast
    |=> polarity_reversed_flag)
    else $error("polarity reversal not flagged");

  chk_strap_default: assert property ( // [R20]
    !q.taken && mode_strap == pvc_pkg::MODE_ALL_CAP
    |=> strap_control_preset[pvc_pkg::C0_AUTONEG] && strap_advert_preset[pvc_pkg::ADV_10])
    else $error("floating straps not all capable");

  chk_coder_byp_write: assert property ( // [R6]
    wr_fast && !reg_wdata[pvc_pkg::FC_SOFT_RST]
    |=> coder_bypass == $past(reg_wdata[pvc_pkg::FC_CODER_BYP]))
    else $error("coder bypass write not applied");

  chk_align_byp_write: assert property ( // [R8]
    wr_fast && !reg_wdata[pvc_pkg::FC_SOFT_RST]
    |=> symbol_aligner_bypass == $past(reg_wdata[pvc_pkg::FC_ALIGN_BYP]))
    else $error("aligner bypass write not applied");

  chk_scram_byp_write: assert property ( // [R9]
    wr_fast && !reg_wdata[pvc_pkg::FC_SOFT_RST]
    |=> scrambler_bypass == $past(reg_wdata[pvc_pkg::FC_SCRAM_BYP]))
    else $error("scrambler bypass write not applied");

  chk_carrier_int_write: assert property ( // [R10]
    wr_fast && !reg_wdata[pvc_pkg::FC_SOFT_RST]
    |=> carrier_integrity_enable == $past(reg_wdata[pvc_pkg::FC_CARR_INT]))
    else $error("carrier integrity write not applied");

  chk_heartbeat_write: assert property ( // [R13]
    wr_ten ##1 !speed_100 |-> heartbeat_active == $past(reg_wdata[pvc_pkg::TC_HBT]))
    else $error("heartbeat enable write not applied");

  chk_squelch_write: assert property ( // [R14]
    wr_ten ##1 !speed_100 |-> squelch_reduced == $past(reg_wdata[pvc_pkg::TC_ELL]))
    else $error("line length write not applied");

  chk_reference_write: assert property ( // [R16]
    wr_ten |=> use_external_reference == $past(reg_wdata[pvc_pkg::TC_REF]))
    else $error("reference select write not applied");

  chk_serial_write: assert property ( // [R17]
    wr_ten ##1 !speed_100 |-> serial_mode_active == $past(reg_wdata[pvc_pkg::TC_SERIAL]))
    else $error("serial select write not applied");

  chk_no_partner_write: assert property ( // [R18]
    wr_ten ##1 !speed_100 |-> no_link_partner_active == $past(reg_wdata[pvc_pkg::TC_NO_LP]))
    else $error("no link partner write not applied");

  chk_ten_at_fast: assert property ( // [R14] [R15]
    speed_100 |-> !squelch_reduced && !polarity_correct_active)
    else $error("squelch or polarity active at 100 Mbit/s");

  chk_strap_fixed: assert property ( // [R21]
    !q.taken && !mode_strap[2]
    |=> !strap_control_preset[pvc_pkg::C0_AUTONEG]
        && strap_control_preset[pvc_pkg::C0_DUPLEX] == $past(mode_strap[0])
        && strap_control_preset[pvc_pkg::C0_SPEED] == $past(mode_strap[1]))
    else $error("fixed strap mode preset wrong");

  chk_strap_fast_half: assert property ( // [R22]
    !q.taken && mode_strap == 3'h4
    |=> strap_control_preset[pvc_pkg::C0_AUTONEG] && strap_control_preset[pvc_pkg::C0_SPEED]
        && strap_advert_preset == 16'h0000)
    else $error("half duplex strap preset wrong");

  chk_strap_isolate: assert property ( // [R23]
    !q.taken && mode_strap == 3'h6
    |=> strap_control_preset[pvc_pkg::C0_ISOLATE] && strap_control_preset[pvc_pkg::C0_SPEED]
        && !strap_advert_preset[pvc_pkg::ADV_TX_FD] && strap_advert_preset[pvc_pkg::ADV_10])
    else $error("isolate strap preset wrong");

  chk_presets_held: assert property ( // [R19]
    q.taken |=> $stable(strap_control_preset) && $stable(strap_advert_preset))
    else $error("strap presets changed after latching");

  chk_soft_clears_flag: assert property ( // [R1] [R24]
    wr_fast && reg_wdata[pvc_pkg::FC_SOFT_RST] |=> !polarity_reversed_flag)
    else $error("soft reset left polarity flag set");

endmodule // pvc_vendor_control
`default_nettype wire

// File: hdl/pvc_pkg.sv
`default_nettype none
package pvc_pkg;
  // Management register addresses
  localparam logic [4:0]  VEND_STAT_ADDR = 5'h1c;
  localparam logic [4:0]  FAST_CTRL_ADDR = 5'h1d;
  localparam logic [4:0]  TEN_CTRL_ADDR  = 5'h1e;
  // fast_mode_control fields
  localparam int          FC_SOFT_RST    = 15;
  localparam int          FC_TEST_A      = 14;
  localparam int          FC_TEST_B      = 13;
  localparam int          FC_TX_ON       = 12;
  localparam int          FC_CRS_RX_ONLY = 10;
  localparam int          FC_LINK_ERR    = 9;
  localparam int          FC_UNLOCK_ERR  = 8;
  localparam int          FC_CODER_BYP   = 6;
  localparam int          FC_ALIGN_BYP   = 5;
  localparam int          FC_SCRAM_BYP   = 4;
  localparam int          FC_CARR_INT    = 3;
  localparam int          FC_JAM_COL     = 2;
  localparam logic [15:0] FAST_RESET     = 16'h1000;
  localparam logic [15:0] FAST_PCS_BYP   = 16'h0050;
  // ten_meg_control fields
  localparam int          TEN_W          = 6;
  localparam int          TC_HBT         = 5;
  localparam int          TC_ELL         = 4;
  localparam int          TC_POL         = 3;
  localparam int          TC_REF         = 2;
  localparam int          TC_SERIAL      = 1;
  localparam int          TC_NO_LP       = 0;
  localparam logic [5:0]  TEN_RESET      = 6'h00;
  // Vendor status polarity flag
  localparam int          VS_POL_FLAG    = 6;
  // Basic control and advertisement bits preset by the straps
  localparam int          C0_SPEED       = 13;
  localparam int          C0_AUTONEG     = 12;
  localparam int          C0_ISOLATE     = 10;
  localparam int          C0_DUPLEX      = 8;
  localparam int          ADV_TX_FD      = 8;
  localparam int          ADV_10_FD      = 6;
  localparam int          ADV_10         = 5;
  localparam logic [2:0]  MODE_ALL_CAP   = 3'h7;
endpackage
`default_nettype wire

// File: hdl/pvc_strap_decode.sv
`timescale 1ns/10ps
`default_nettype none
module pvc_strap_decode
(
  input  wire logic [2:0]  mode_strap,
  output logic      [15:0] control_bits,
  output logic      [15:0] advert_bits
);
  logic [3:0] c;
  logic [2:0] a;

  // c = {speed, autoneg, isolate, duplex}, a = {tx_fd, 10_fd, 10}
  always_comb
  begin
    unique case (mode_strap)
      3'h0:    {c, a} = {4'h0, 3'h5};
      3'h1:    {c, a} = {4'h1, 3'h7};
      3'h2:    {c, a} = {4'h8, 3'h4};
      3'h3:    {c, a} = {4'h9, 3'h4};
      3'h4:    {c, a} = {4'hc, 3'h0};
      3'h6:    {c, a} = {4'ha, 3'h3};
      default: {c, a} = {4'hc, 3'h7};
    endcase
    control_bits = 16'h0000;
    advert_bits  = 16'h0000;
    control_bits[pvc_pkg::C0_SPEED]   = c[3];
    control_bits[pvc_pkg::C0_AUTONEG] = c[2];
    control_bits[pvc_pkg::C0_ISOLATE] = c[1];
    control_bits[pvc_pkg::C0_DUPLEX]  = c[0];
    advert_bits[pvc_pkg::ADV_TX_FD]   = a[2];
    advert_bits[pvc_pkg::ADV_10_FD]   = a[1];
    advert_bits[pvc_pkg::ADV_10]      = a[0];
  end
endmodule // pvc_strap_decode
`default_nettype wire

// File: tb/pvc_mgmt_host.sv
`timescale 1ns/10ps
`default_nettype none
module pvc_mgmt_host
(
  input  wire logic        clk,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_rvalid,
  output logic      [4:0]  reg_addr,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [15:0] reg_wdata
);
  initial
  begin
    reg_addr  = 5'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lines go to the inverse once released, so stale values never pass
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] v;
    v = (a == pvc_pkg::FAST_CTRL_ADDR) ? (d & 16'hf77c) : d;
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = v;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~v;
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic ok);
    @(negedge clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = reg_rdata;
    ok       = reg_rvalid;
  endtask
endmodule // pvc_mgmt_host
`default_nettype wire

// File: tb/test_phy_vendor_control_and_mode_straps.sv
`timescale 1ns/10ps
`default_nettype none
module test_phy_vendor_control_and_mode_straps;
  logic        clk = 1'b0, reset_n = 1'b0, coding_sublayer_enable_strap = 1'b1;
  logic [2:0]  mode_strap = 3'h7;
  logic [4:0]  reg_addr;
  logic        reg_wr, reg_rd, reg_rvalid, soft_register_reset;
  logic [15:0] reg_wdata, reg_rdata, strap_control_preset, strap_advert_preset;
  logic        factory_test_reset_a, factory_test_reset_b, coder_bypass;
  logic        symbol_aligner_bypass, scrambler_bypass, carrier_integrity_enable;
  logic        heartbeat_active, squelch_reduced, polarity_correct_active;
  logic        use_external_reference, serial_mode_active, no_link_partner_active;
  logic        speed_100 = 1'b0, tx_line_p_in = 1'b1, tx_line_n_in = 1'b0;
  logic        rx_active = 1'b0, tx_active = 1'b0, rx_er = 1'b0, scrambler_unlocked = 1'b0;
  logic        col_in = 1'b0, jam_in = 1'b0, polarity_reversal_seen = 1'b0;
  logic        line_p, line_n, crs, col, polarity_reversed_flag;
  logic [3:0]  rxd_in = 4'ha, link_error_code = 4'h5, rxd;
  logic [15:0] d;
  logic        ok;
  int          failures = 0;
  int          n_compared = 0;

  typedef struct {logic [2:0] code; logic [15:0] ctrl; logic [15:0] adv;} pvc_row_t;
  pvc_row_t rows [8] = '{
    '{3'h0, 16'h0000, 16'h0120}, '{3'h1, 16'h0100, 16'h0160},
    '{3'h2, 16'h2000, 16'h0100}, '{3'h3, 16'h2100, 16'h0100},
    '{3'h4, 16'h3000, 16'h0000}, '{3'h5, 16'h3000, 16'h0160},
    '{3'h6, 16'h2400, 16'h0060}, '{3'h7, 16'h3000, 16'h0160}};

  pvc_vendor_control pvc_vendor_control_inst (
    .clk, .reset_n, .mode_strap, .coding_sublayer_enable_strap, .reg_addr, .reg_wr,
    .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .soft_register_reset,
    .strap_control_preset, .strap_advert_preset, .factory_test_reset_a,
    .factory_test_reset_b, .coder_bypass, .symbol_aligner_bypass, .scrambler_bypass,
    .carrier_integrity_enable, .heartbeat_active, .squelch_reduced,
    .polarity_correct_active, .use_external_reference, .serial_mode_active,
    .no_link_partner_active, .speed_100, .tx_line_p_in, .tx_line_n_in, .line_p, .line_n,
    .rx_active, .tx_active, .crs, .rx_er, .rxd_in, .link_error_code,
    .scrambler_unlocked, .rxd, .col_in, .jam_in, .col, .polarity_reversal_seen,
    .polarity_reversed_flag);

  pvc_mgmt_host pvc_mgmt_host_inst (.clk, .reg_rdata, .reg_rvalid, .reg_addr, .reg_wr,
    .reg_rd, .reg_wdata);

  initial
  begin
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic do_reset(input logic [2:0] code, input logic cse);
    reset_n = 1'b0;
    mode_strap = code;
    coding_sublayer_enable_strap = cse;
    repeat (10) @(negedge clk);
    chk("line_n in reset", line_n, 16'h1);
    reset_n = 1'b1;
    @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #200us;
    failures++;
    final_report();
  end

  initial
  begin
    for (int i = 0; i < 8; i++)
    begin
      do_reset(rows[i].code, rows[i].code[0]);
      chk("ctrl preset", strap_control_preset, rows[i].ctrl);
      chk("adv preset", strap_advert_preset, rows[i].adv);
      chk("coder bypass", coder_bypass, {15'h0, ~rows[i].code[0]});
      pvc_mgmt_host_inst.rd(pvc_pkg::FAST_CTRL_ADDR, d, ok);
      chk("fast reset", d, rows[i].code[0] ? 16'h1000 : 16'h1050);
      pvc_mgmt_host_inst.rd(pvc_pkg::TEN_CTRL_ADDR, d, ok);
      chk("ten reset", d, 16'h0000);
    end
    pvc_mgmt_host_inst.wr(pvc_pkg::FAST_CTRL_ADDR, 16'h777c);
    pvc_mgmt_host_inst.rd(pvc_pkg::FAST_CTRL_ADDR, d, ok);
    chk("fast rd", d, 16'h777c);
    chk("rvalid", ok, 16'h1);
    chk("factory bits", {factory_test_reset_a, factory_test_reset_b}, 16'h3);
    chk("bypass", {coder_bypass, symbol_aligner_bypass, scrambler_bypass,
        carrier_integrity_enable}, 16'hf);
    tx_active = 1'b1;
    rx_er = 1'b1;
    scrambler_unlocked = 1'b1;
    jam_in = 1'b1;
    @(negedge clk);
    chk("crs rx only", crs, 16'h0);
    chk("rxd link", rxd, 16'h5);
    chk("col jam", col, 16'h1);
    chk("line on", {line_p, line_n}, 16'h2);
    pvc_mgmt_host_inst.wr(pvc_pkg::FAST_CTRL_ADDR, 16'h0100);
    @(negedge clk);
    chk("crs tx", crs, 16'h1);
    chk("rxd unlocked", rxd, 16'h2);
    chk("col no jam", col, 16'h0);
    chk("line idle", {line_p, line_n}, 16'h1);
    chk("bypass off", {coder_bypass, scrambler_bypass}, 16'h0);
    chk("factory off", {factory_test_reset_a, factory_test_reset_b}, 16'h0);
    rx_er = 1'b0;
    @(negedge clk);
    chk("rxd pass", rxd, 16'ha);
    polarity_reversal_seen = 1'b1;
    pvc_mgmt_host_inst.wr(pvc_pkg::TEN_CTRL_ADDR, 16'hffff);
    pvc_mgmt_host_inst.rd(pvc_pkg::TEN_CTRL_ADDR, d, ok);
    chk("ten rd", d, 16'h003f);
    chk("ten out", {heartbeat_active, squelch_reduced, polarity_correct_active,
        use_external_reference, serial_mode_active, no_link_partner_active},
        16'h3f);
    pvc_mgmt_host_inst.rd(pvc_pkg::VEND_STAT_ADDR, d, ok);
    chk("pol flag", d, 16'h0040);
    chk("pol flag pin", polarity_reversed_flag, 16'h1);
    speed_100 = 1'b1;
    @(negedge clk);
    chk("ten at 100", {heartbeat_active, squelch_reduced, polarity_correct_active,
        use_external_reference, serial_mode_active, no_link_partner_active},
        16'h04);
    chk("pol flag at 100", polarity_reversed_flag, 16'h0);
    pvc_mgmt_host_inst.wr(pvc_pkg::FAST_CTRL_ADDR, 16'h8000);
    chk("soft pulse", soft_register_reset, 16'h1);
    @(negedge clk);
    chk("soft pulse end", soft_register_reset, 16'h0);
    pvc_mgmt_host_inst.rd(pvc_pkg::FAST_CTRL_ADDR, d, ok);
    chk("fast soft", d, 16'h1000);
    pvc_mgmt_host_inst.rd(5'h05, d, ok);
    chk("unmapped", d, 16'h0000);
    chk("unmapped valid", ok, 16'h1);
    final_report();
  end
endmodule // test_phy_vendor_control_and_mode_straps
`default_nettype wire
